// ### design/asrc_defines.vh
// Constants for the asynchronous static memory host controller
// Function
// - Write only while both selects and strobe active
// - Host holds selects long before write end
// - Host holds address valid through whole cycle
// - Address valid by write window start
// - Host keeps write window open long enough
// - Host sets up write data before end
// - Host never drives against device outputs
// - Gate-low writes cover overlap plus float delay
// - Active-high select low gates inputs in retention
// - Deselect before retention, then wait recovery
`ifndef ASRC_DEFINES_VH
`define ASRC_DEFINES_VH
`define ASRC_ADDR_W 17
`define ASRC_DATA_W 8
`define ASRC_CLK_NS 100
// Slowest grade figures, so every grade is served
`define ASRC_READ_CYCLE_NS 85
`define ASRC_SELECT_TO_VALID_NS 85
`define ASRC_GATE_TO_VALID_NS 45
`define ASRC_DESELECT_TO_FLOAT_NS 30
`define ASRC_WRITE_WINDOW_NS 75
`define ASRC_DATA_BEFORE_END_NS 35
`define ASRC_RECOVERY_MS 5
// Nanosecond least times round up, plus one spare cycle
`define ASRC_CYC_UP(ns) (((ns) + `ASRC_CLK_NS - 1) / `ASRC_CLK_NS + 1)
`define ASRC_READ_CYC `ASRC_CYC_UP(`ASRC_SELECT_TO_VALID_NS)
`define ASRC_WRITE_CYC `ASRC_CYC_UP(`ASRC_WRITE_WINDOW_NS)
`define ASRC_FLOAT_CYC `ASRC_CYC_UP(`ASRC_DESELECT_TO_FLOAT_NS)
`define ASRC_RECOVERY_CYC ((`ASRC_RECOVERY_MS * 1000000) / `ASRC_CLK_NS)
`define ASRC_CNT_W 16
`endif

// ### design/asrc_host.v
// Host controller sequencing reads, writes and retention of the memory
`timescale 1ns/100ps
`include "asrc_defines.vh"
module asrc_host
#(
  parameter RECOVERY_CYC = `ASRC_RECOVERY_CYC
)
(
  input  wire                      clk_i,
  input  wire                      reset_i,
  input  wire                      req_i,
  input  wire                      req_write_i,
  input  wire [`ASRC_ADDR_W-1:0]   req_addr_i,
  input  wire [`ASRC_DATA_W-1:0]   req_wdata_i,
  input  wire                      retain_i,
  output reg                       busy_o,
  output reg                       done_o,
  output reg  [`ASRC_DATA_W-1:0]   rdata_o,
  output reg                       retained_o,
  output reg  [`ASRC_ADDR_W-1:0]   mem_addr_o,
  output reg                       select_active_low_n_o,
  output reg                       select_active_high_o,
  output reg                       write_strobe_n_o,
  output reg                       output_gate_n_o,
  output reg  [`ASRC_DATA_W-1:0]   mem_data_o,
  output reg                       mem_data_oe_n_o,
  input  wire [`ASRC_DATA_W-1:0]   mem_data_i
);
  localparam [6:0] ST_IDLE   = 7'h01;
  localparam [6:0] ST_READ   = 7'h02;
  localparam [6:0] ST_WRITE  = 7'h04;
  localparam [6:0] ST_FLOAT  = 7'h08;
  localparam [6:0] ST_RETAIN = 7'h10;
  localparam [6:0] ST_RECOV  = 7'h20;
  localparam [6:0] ST_SETUP  = 7'h40;

  reg [6:0]               state;
  reg [`ASRC_CNT_W-1:0]   count;
  reg [`ASRC_DATA_W-1:0]  data_meta;
  reg [`ASRC_DATA_W-1:0]  data_sync;
  reg                     retain_meta;
  reg                     retain_sync;

  // Two extra cycles let read data cross the synchroniser
  localparam integer READ_LOAD  = `ASRC_READ_CYC + 2;
  localparam integer WRITE_LOAD = `ASRC_WRITE_CYC;
  localparam integer FLOAT_LOAD = `ASRC_FLOAT_CYC;

  // Counters end at one so a load of N lasts N cycles
  function cnt_last;
    input [`ASRC_CNT_W-1:0] value;
    begin
      cnt_last = (value == {{(`ASRC_CNT_W-1){1'b0}}, 1'b1});
    end
  endfunction

  function [`ASRC_CNT_W-1:0] cnt_dec;
    input [`ASRC_CNT_W-1:0] value;
    begin
      cnt_dec = value - {{(`ASRC_CNT_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // Cycle counts are integers; cut to the counter on purpose
  function [`ASRC_CNT_W-1:0] cnt_load;
    input integer cycles;
    begin
      cnt_load = cycles[`ASRC_CNT_W-1:0];
    end
  endfunction

  // Memory pins are foreign to this clock
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      data_meta   <= {`ASRC_DATA_W{1'b0}};
      data_sync   <= {`ASRC_DATA_W{1'b0}};
      retain_meta <= 1'b0;
      retain_sync <= 1'b0;
    end
    else
    begin
      data_meta   <= mem_data_i;
      data_sync   <= data_meta;
      retain_meta <= retain_i;
      retain_sync <= retain_meta;
    end
  end

  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state                 <= ST_IDLE;
      count                 <= {`ASRC_CNT_W{1'b0}};
      busy_o                <= 1'b0;
      done_o                <= 1'b0;
      rdata_o               <= {`ASRC_DATA_W{1'b0}};
      retained_o            <= 1'b0;
      mem_addr_o            <= {`ASRC_ADDR_W{1'b0}};
      select_active_low_n_o <= 1'b1;
      select_active_high_o  <= 1'b0;
      write_strobe_n_o      <= 1'b1;
      output_gate_n_o       <= 1'b1;
      mem_data_o            <= {`ASRC_DATA_W{1'b0}};
      mem_data_oe_n_o       <= 1'b1;
    end
    else
    begin
      done_o <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (retain_sync)
          begin
            // Deselect first, retention follows next cycle
            select_active_low_n_o <= 1'b1;
            select_active_high_o  <= 1'b0;
            // Other controls parked firm, host data released
            write_strobe_n_o      <= 1'b1;
            output_gate_n_o       <= 1'b1;
            mem_data_oe_n_o       <= 1'b1;
            busy_o                <= 1'b1;
            state                 <= ST_RETAIN;
          end
          else if (req_i)
          begin
            busy_o     <= 1'b1;
            mem_addr_o <= req_addr_i;
            if (req_write_i)
            begin
              // Gate kept high so device never drives
              output_gate_n_o <= 1'b1;
              mem_data_o      <= req_wdata_i;
              mem_data_oe_n_o <= 1'b0;
              state           <= ST_SETUP;
            end
            else
            begin
              write_strobe_n_o      <= 1'b1;
              select_active_low_n_o <= 1'b0;
              select_active_high_o  <= 1'b1;
              output_gate_n_o       <= 1'b0;
              count <= cnt_load(READ_LOAD);
              state <= ST_READ;
            end
          end
        end
        ST_SETUP:
        begin
          // Selects and strobe together open the window
          select_active_low_n_o <= 1'b0;
          select_active_high_o  <= 1'b1;
          write_strobe_n_o      <= 1'b0;
          count <= cnt_load(WRITE_LOAD);
          state <= ST_WRITE;
        end
        ST_WRITE:
        begin
          if (cnt_last(count))
          begin
            // Strobe ends the write; data, address held one more cycle
            write_strobe_n_o      <= 1'b1;
            select_active_low_n_o <= 1'b1;
            select_active_high_o  <= 1'b0;
            count <= cnt_load(FLOAT_LOAD);
            state <= ST_FLOAT;
          end
          else
            count <= cnt_dec(count);
        end
        ST_READ:
        begin
          if (cnt_last(count))
          begin
            rdata_o               <= data_sync;
            output_gate_n_o       <= 1'b1;
            select_active_low_n_o <= 1'b1;
            select_active_high_o  <= 1'b0;
            // Wait out the float time before host may drive
            count <= cnt_load(FLOAT_LOAD);
            state <= ST_FLOAT;
          end
          else
            count <= cnt_dec(count);
        end
        ST_FLOAT:
        begin
          mem_data_oe_n_o <= 1'b1;
          if (cnt_last(count))
          begin
            busy_o <= 1'b0;
            done_o <= 1'b1;
            state  <= ST_IDLE;
          end
          else
            count <= cnt_dec(count);
        end
        ST_RETAIN:
        begin
          retained_o <= 1'b1;
          if (!retain_sync)
          begin
            retained_o <= 1'b0;
            count <= RECOVERY_CYC[`ASRC_CNT_W-1:0];
            state <= ST_RECOV;
          end
        end
        ST_RECOV:
        begin
          if (count <= {{(`ASRC_CNT_W-1){1'b0}}, 1'b1})
          begin
            busy_o <= 1'b0;
            state  <= ST_IDLE;
          end
          else
            count <= cnt_dec(count);
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end
endmodule

// ### bench/asrc_mem_model.sv
// Behavioural model of the static memory at the host's far side
`timescale 1ns/100ps
`include "asrc_defines.vh"
module asrc_mem_model
#(
  parameter DLY = 40,
  parameter OFF = 20
)
(
  input  wire [`ASRC_ADDR_W-1:0] addr_i,
  input  wire                    sel_n_i,
  input  wire                    sel_i,
  input  wire                    we_n_i,
  input  wire                    oe_n_i,
  input  wire [7:0]              din_i,
  input  wire                    din_oe_n_i,
  output wire [7:0]              dout_o
);
  reg  [7:0] mem [0:(1<<`ASRC_ADDR_W)-1];
  reg  [7:0] last = 8'h00;
  reg  [7:0] out  = 8'h00;
  wire       en   = !sel_n_i && sel_i;
  wire       drv  = en && !oe_n_i && we_n_i;
  // Floating bus shows the inverse, never a stale match
  wire [7:0] q    = drv ? mem[addr_i] : ~last;
  always @(en, we_n_i, addr_i, din_i, din_oe_n_i)
    if (en && !we_n_i)
      mem[addr_i] = din_oe_n_i ? ~last : din_i;
  always @(negedge drv)
    last <= mem[addr_i];
  // Turn-off beats turn-on so a shared bus never overlaps
  always @(q, drv)
    if (drv)
      out <= #DLY q;
    else
      out <= #OFF q;
  assign dout_o = out;
endmodule

// ### bench/asrc_host_asserts.sv
// Checker of the host's memory pin sequencing
`timescale 1ns/100ps
`include "asrc_defines.vh"
module asrc_host_asserts
#(
  parameter RECOVERY_CYC = 4
)
(
  input wire                    clk_i,
  input wire                    reset_i,
  input wire                    retained_o,
  input wire [`ASRC_ADDR_W-1:0] mem_addr_o,
  input wire                    select_active_low_n_o,
  input wire                    select_active_high_o,
  input wire                    write_strobe_n_o,
  input wire                    output_gate_n_o,
  input wire [`ASRC_DATA_W-1:0] mem_data_o,
  input wire                    mem_data_oe_n_o
);
  reg [15:0] rec;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  always @(posedge clk_i)
    if (reset_i)
      rec <= 16'h0;
    else if ($fell(retained_o))
      rec <= RECOVERY_CYC[15:0];
    else if (rec != 16'h0)
      rec <= rec - 16'h1;
  sequence win_start;
    $fell(write_strobe_n_o);
  endsequence
  win_len_a: assert property (win_start |=> !write_strobe_n_o)
    else $error("write window too short");
  data_setup_a: assert property (win_start |->
    $past(!mem_data_oe_n_o) && !mem_data_oe_n_o) else $error("late data");
  data_hold_a: assert property (!write_strobe_n_o |->
    !mem_data_oe_n_o && $stable(mem_data_o)) else $error("data moved");
  addr_hold_a: assert property ($past(!select_active_low_n_o) &&
    !select_active_low_n_o |-> $stable(mem_addr_o)) else $error("addr moved");
  in_window_a: assert property (!write_strobe_n_o |->
    !select_active_low_n_o && select_active_high_o) else $error("bad window");
  sel_hold_a: assert property ($rose(write_strobe_n_o) |->
    $past(!select_active_low_n_o, 2)) else $error("select too short");
  no_fight_a: assert property (!mem_data_oe_n_o |->
    output_gate_n_o && $past(output_gate_n_o)) else $error("bus fight");
  read_gate_a: assert property (!output_gate_n_o |->
    write_strobe_n_o && !select_active_low_n_o) else $error("bad read");
  retain_a: assert property (retained_o |->
    select_active_low_n_o && !select_active_high_o) else $error("selected");
  recover_a: assert property (rec != 16'h0 |-> select_active_low_n_o)
    else $error("access during recovery");
endmodule
bind asrc_host asrc_host_asserts #(.RECOVERY_CYC(RECOVERY_CYC)) chk_inst (
  .clk_i                 (clk_i),
  .reset_i               (reset_i),
  .retained_o            (retained_o),
  .mem_addr_o            (mem_addr_o),
  .select_active_low_n_o (select_active_low_n_o),
  .select_active_high_o  (select_active_high_o),
  .write_strobe_n_o      (write_strobe_n_o),
  .output_gate_n_o       (output_gate_n_o),
  .mem_data_o            (mem_data_o),
  .mem_data_oe_n_o       (mem_data_oe_n_o)
);

// ### bench/testbench.sv
// Self-checking bench of the memory host controller
`timescale 1ns/100ps
`include "asrc_defines.vh"
module testbench;
  reg         clk_i = 1'b0;
  reg         reset_i = 1'b1;
  reg         req_i = 1'b0;
  reg         req_write_i = 1'b0;
  reg  [16:0] req_addr_i = 17'h0;
  reg  [7:0]  req_wdata_i = 8'h0;
  reg  [16:0] a;
  reg  [7:0]  d;
  reg         retain_i = 1'b0;
  wire        busy_o, done_o, retained_o, sn, sh, wn, gn, doe;
  wire [7:0]  rdata_o, mdo, mdi;
  wire [16:0] ma;
  int         miscompares = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  reg  [7:0]  ref_m [int];
  always #50 clk_i = ~clk_i;
  asrc_host #(.RECOVERY_CYC(4)) asrc_host_inst (.clk_i(clk_i),
    .reset_i(reset_i), .req_i(req_i), .req_write_i(req_write_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .retain_i(retain_i),
    .busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o),
    .retained_o(retained_o), .mem_addr_o(ma), .select_active_low_n_o(sn),
    .select_active_high_o(sh), .write_strobe_n_o(wn), .output_gate_n_o(gn),
    .mem_data_o(mdo), .mem_data_oe_n_o(doe), .mem_data_i(mdi));
  asrc_mem_model asrc_mem_model_inst (.addr_i(ma), .sel_n_i(sn), .sel_i(sh),
    .we_n_i(wn), .oe_n_i(gn), .din_i(mdo), .din_oe_n_i(doe), .dout_o(mdi));
  task summarize;
    if (miscompares == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task chk_bit(input got, input exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t flag %b want %b", $time, got, exp);
    end
  endtask
  function [7:0] expect_at(input [16:0] ad);
    expect_at = ref_m[ad];
  endfunction
  // Request held one edge only, so a late edge cannot retrigger it
  task op(input w, input [16:0] ad, input [7:0] dt);
    req_write_i = w;
    req_addr_i = ad;
    req_wdata_i = dt;
    req_i = 1'b1;
    @(negedge clk_i) req_i = 1'b0;
    chk_bit(busy_o, 1'b1);
    while (done_o !== 1'b1) @(negedge clk_i);
    chk_bit(busy_o, 1'b0);
    if (w)
      ref_m[ad] = dt;
    else
      chk(rdata_o, expect_at(ad));
    @(negedge clk_i);
    chk_bit(done_o, 1'b0);
  endtask
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      miscompares++;
      summarize;
    end
  end
  initial
  begin
    void'($urandom(32'h64f2));
    repeat (4) @(negedge clk_i);
    reset_i = 1'b0;
    op(1'b1, 17'h0, 8'h5a);
    op(1'b1, 17'h1ffff, 8'ha5);
    op(1'b0, 17'h0, 8'h0);
    op(1'b0, 17'h1ffff, 8'h0);
    repeat (30)
    begin
      a = 17'($urandom);
      d = 8'($urandom);
      op(1'b1, a, d);
      op(1'b0, a, 8'h0);
    end
    retain_i = 1'b1;
    while (retained_o !== 1'b1) @(negedge clk_i);
    chk({6'h0, sh, sn}, 8'h1);
    chk_bit(busy_o, 1'b1);
    retain_i = 1'b0;
    while (retained_o !== 1'b0) @(negedge clk_i);
    chk_bit(busy_o, 1'b1);
    while (busy_o !== 1'b0) @(negedge clk_i);
    op(1'b0, 17'h0, 8'h0);
    summarize;
  end
endmodule
